// *** common/stmh_pkg.sv ***
// shared constants for the target message handler and its initiator end
package stmh_pkg;
	localparam logic [7:0] MSG_COMPLETE = 8'h00;
	localparam logic [7:0] MSG_SAVE_PTR = 8'h02;
	localparam logic [7:0] MSG_DISCONNECT = 8'h04;
	localparam logic [7:0] MSG_ABORT = 8'h06;
	localparam logic [7:0] MSG_REJECT = 8'h07;
	localparam logic [7:0] MSG_DEV_RESET = 8'h0C;
	localparam logic [7:0] MSG_SIMPLE_TAG = 8'h20;
	localparam logic [7:0] MSG_WIDE_RESIDUE = 8'h23;
	// ignore-count codes of the residue message
	localparam logic [7:0] IGN_W32_HI8 = 8'h01;
	localparam logic [7:0] IGN_W32_HI16 = 8'h02;
	localparam logic [7:0] IGN_W32_HI24 = 8'h03;
	localparam logic [7:0] IGN_W16_HI8 = 8'h01;
	// identification byte layout
	localparam int ID_FLAG_BIT = 7;
	localparam int ID_DISC_BIT = 6;
	localparam int ID_ROUTINE_BIT = 5;
	localparam int ID_RSV_HI_BIT = 4;
	localparam int ID_RSV_LO_BIT = 3;
	localparam int ID_NUM_MSB = 2;
	// commands allowed for a target routine
	localparam logic [7:0] OP_INQUIRY = 8'h12;
	localparam logic [7:0] OP_REQ_SENSE = 8'h03;
	// re-arbitration hold-off, in clock cycles, then message queue index and length values
	localparam int HOLD_W = 16;
	localparam logic [HOLD_W-1:0] DISC_DELAY_CYC = 16'h0040;
	localparam logic [HOLD_W-1:0] HOLD_ZERO = 16'h0000;
	localparam logic [HOLD_W-1:0] HOLD_ONE = 16'h0001;
	localparam logic [1:0] QIDX_ZERO = 2'h0;
	localparam logic [1:0] QIDX_ONE = 2'h1;
	localparam logic [1:0] QLEN_ONE = 2'h1;
	localparam logic [1:0] QLEN_TWO = 2'h2;
	localparam logic [1:0] QLEN_THREE = 2'h3;
endpackage

// *** common/stmh_bus_if.sv ***
// message-phase bus between target and initiator
`timescale 1ns/1ps
interface stmh_bus_if;
	logic bsy;
	logic req;
	logic io;
	logic msgp;
	logic [7:0] tdata;
	logic tpar;
	logic ack;
	logic atn;
	logic [7:0] idata;
	logic ipar;
	modport target (output bsy, output req, output io, output msgp, output tdata, output tpar,
		input ack, input atn, input idata, input ipar);
	modport initiator (input bsy, input req, input io, input msgp, input tdata, input tpar,
		output ack, output atn, output idata, output ipar);
endinterface

// *** design/stmh_target.sv ***
// target end: message phases, identification and bus release
`timescale 1ns/1ps
module stmh_target #(
	parameter logic [15:0] DISC_DELAY = stmh_pkg::DISC_DELAY_CYC
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	stmh_bus_if.target bus,
	input wire logic select_i,
	input wire logic reselect_i,
	input wire logic [2:0] reselect_unit_i,
	input wire logic reselect_routine_i,
	input wire logic reselect_tagged_i,
	input wire logic [7:0] reselect_tag_i,
	input wire logic complete_i,
	input wire logic disconnect_i,
	input wire logic save_ptr_i,
	input wire logic residue_i,
	input wire logic [7:0] residue_code_i,
	input wire logic routines_en_i,
	input wire logic init_disc_en_i,
	input wire logic can_disc_i,
	input wire logic [15:0] disc_limit_i,
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_opcode_i,
	output logic connected_o,
	output logic id_valid_o,
	output logic [2:0] unit_or_routine_number_o,
	output logic routine_select_flag_o,
	output logic disconnect_permission_o,
	output logic id_ok_o,
	output logic id_bad_o,
	output logic unexpected_free_o,
	output logic delivered_o,
	output logic arb_hold_o,
	output logic cmd_illegal_o
);
	typedef enum {ST_FREE, ST_CONN, ST_MO_REQ, ST_MO_ACK, ST_MI_REQ, ST_MI_ACK} stmh_tstate_t;

	stmh_tstate_t st_ff;
	logic bsy_ff, req_ff, io_ff;
	logic [7:0] dout_ff, din_ff;
	logic [7:0] q_ff [0:2];
	logic [1:0] qlen_ff, qidx_ff;
	logic rel_ff, hold_after_ff, first_ff, reconn_ff, atn_seen_ff;
	logic idv_ff, rsel_ff, dperm_ff;
	logic [2:0] unit_ff;
	logic ok_ff, bad_ff, unexp_ff, dlv_ff, illegal_ff, hold_load_ff;
	logic [15:0] hold_ff, nxt_hold;
	logic arb_hold_ff, tpar_ff, dpok_ff;

	function automatic logic [15:0] stmh_max16(input logic [15:0] a, input logic [15:0] b);
		stmh_max16 = (a > b) ? a : b;
	endfunction

	function automatic logic stmh_id_bad(input logic [7:0] b, input logic routines);
		stmh_id_bad = b[stmh_pkg::ID_RSV_HI_BIT] | b[stmh_pkg::ID_RSV_LO_BIT] |
			(b[stmh_pkg::ID_ROUTINE_BIT] & ~routines);
	endfunction

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			st_ff <= ST_FREE;
			bsy_ff <= 1'b0;
			req_ff <= 1'b0;
			io_ff <= 1'b0;
			dout_ff <= 8'h00;
			tpar_ff <= 1'b1;
			din_ff <= 8'h00;
			dpok_ff <= 1'b0;
			q_ff[0] <= 8'h00;
			q_ff[1] <= 8'h00;
			q_ff[2] <= 8'h00;
			qlen_ff <= 2'h0;
			qidx_ff <= 2'h0;
			rel_ff <= 1'b0;
			hold_after_ff <= 1'b0;
			first_ff <= 1'b0;
			reconn_ff <= 1'b0;
			atn_seen_ff <= 1'b0;
			idv_ff <= 1'b0;
			rsel_ff <= 1'b0;
			dperm_ff <= 1'b0;
			unit_ff <= 3'h0;
			ok_ff <= 1'b0;
			bad_ff <= 1'b0;
			unexp_ff <= 1'b0;
			dlv_ff <= 1'b0;
			hold_load_ff <= 1'b0;
		end
		else
		begin
			ok_ff <= 1'b0;
			bad_ff <= 1'b0;
			unexp_ff <= 1'b0;
			dlv_ff <= 1'b0;
			hold_load_ff <= 1'b0;
			unique case (st_ff)
				ST_FREE:
				begin
					// identity only lives for one connection
					idv_ff <= 1'b0;
					rsel_ff <= 1'b0;
					dperm_ff <= 1'b0;
					unit_ff <= 3'h0;
					if (select_i)
					begin
						bsy_ff <= 1'b1;
						first_ff <= 1'b1;
						reconn_ff <= 1'b0;
						io_ff <= 1'b0;
						req_ff <= 1'b1;
						st_ff <= ST_MO_REQ;
					end
					else if (reselect_i && hold_ff == stmh_pkg::HOLD_ZERO)
					begin
						bsy_ff <= 1'b1;
						reconn_ff <= 1'b1;
						atn_seen_ff <= 1'b0;
						idv_ff <= 1'b1;
						rsel_ff <= reselect_routine_i;
						unit_ff <= reselect_unit_i;
						// permission bit is driven zero by the target
						q_ff[0] <= {1'b1, 1'b0, reselect_routine_i, 2'b00, reselect_unit_i};
						q_ff[1] <= stmh_pkg::MSG_SIMPLE_TAG;
						q_ff[2] <= reselect_tag_i;
						qlen_ff <= reselect_tagged_i ? stmh_pkg::QLEN_THREE : stmh_pkg::QLEN_ONE;
						qidx_ff <= stmh_pkg::QIDX_ZERO;
						rel_ff <= 1'b0;
						st_ff <= ST_MI_REQ;
					end
				end
				ST_CONN:
				begin
					qidx_ff <= stmh_pkg::QIDX_ZERO;
					hold_after_ff <= 1'b0;
					if (bus.atn)
					begin
						io_ff <= 1'b0;
						req_ff <= 1'b1;
						st_ff <= ST_MO_REQ;
					end
					else if (residue_i)
					begin
						q_ff[0] <= stmh_pkg::MSG_WIDE_RESIDUE;
						q_ff[1] <= residue_code_i;
						qlen_ff <= stmh_pkg::QLEN_TWO;
						rel_ff <= 1'b0;
						st_ff <= ST_MI_REQ;
					end
					else if (complete_i)
					begin
						q_ff[0] <= stmh_pkg::MSG_COMPLETE;
						qlen_ff <= stmh_pkg::QLEN_ONE;
						rel_ff <= 1'b1;
						st_ff <= ST_MI_REQ;
					end
					else if (disconnect_i && dperm_ff)
					begin
						q_ff[0] <= stmh_pkg::MSG_SAVE_PTR;
						q_ff[1] <= stmh_pkg::MSG_DISCONNECT;
						qidx_ff <= save_ptr_i ? stmh_pkg::QIDX_ZERO : stmh_pkg::QIDX_ONE;
						qlen_ff <= stmh_pkg::QLEN_TWO;
						rel_ff <= 1'b1;
						hold_after_ff <= 1'b1;
						st_ff <= ST_MI_REQ;
					end
				end
				ST_MO_REQ:
					if (bus.ack)
					begin
						din_ff <= bus.idata;
						// odd parity over the byte; a bad byte only withholds the id_ok_o pulse, the identity is still taken
						dpok_ff <= ^{bus.idata, bus.ipar};
						req_ff <= 1'b0;
						st_ff <= ST_MO_ACK;
					end
				ST_MO_ACK:
					if (!bus.ack)
					begin
						first_ff <= 1'b0;
						qidx_ff <= stmh_pkg::QIDX_ZERO;
						rel_ff <= 1'b0;
						hold_after_ff <= 1'b0;
						if (din_ff[stmh_pkg::ID_FLAG_BIT])
						begin
							if (idv_ff && (din_ff[stmh_pkg::ID_ROUTINE_BIT] != rsel_ff ||
								din_ff[stmh_pkg::ID_NUM_MSB:0] != unit_ff))
							begin
								unexp_ff <= 1'b1;
								bsy_ff <= 1'b0;
								st_ff <= ST_FREE;
							end
							else if (stmh_id_bad(din_ff, routines_en_i))
							begin
								// answered by reject rather than check condition
								bad_ff <= 1'b1;
								q_ff[0] <= stmh_pkg::MSG_REJECT;
								qlen_ff <= stmh_pkg::QLEN_ONE;
								st_ff <= ST_MI_REQ;
							end
							else
							begin
								idv_ff <= 1'b1;
								rsel_ff <= din_ff[stmh_pkg::ID_ROUTINE_BIT];
								unit_ff <= din_ff[stmh_pkg::ID_NUM_MSB:0];
								dperm_ff <= din_ff[stmh_pkg::ID_DISC_BIT];
								ok_ff <= first_ff & dpok_ff;
								st_ff <= bus.atn ? ST_MO_REQ : ST_CONN;
								req_ff <= bus.atn;
							end
						end
						else if (din_ff == stmh_pkg::MSG_ABORT || din_ff == stmh_pkg::MSG_DEV_RESET)
						begin
							bsy_ff <= 1'b0;
							st_ff <= ST_FREE;
						end
						else if (first_ff)
						begin
							unexp_ff <= 1'b1;
							bsy_ff <= 1'b0;
							st_ff <= ST_FREE;
						end
						else if (din_ff == stmh_pkg::MSG_DISCONNECT)
						begin
							st_ff <= ST_MI_REQ;
							if (init_disc_en_i && can_disc_i && dperm_ff)
							begin
								q_ff[0] <= stmh_pkg::MSG_SAVE_PTR;
								q_ff[1] <= stmh_pkg::MSG_DISCONNECT;
								qidx_ff <= save_ptr_i ? stmh_pkg::QIDX_ZERO : stmh_pkg::QIDX_ONE;
								qlen_ff <= stmh_pkg::QLEN_TWO;
								rel_ff <= 1'b1;
								hold_after_ff <= 1'b1;
							end
							else
							begin
								q_ff[0] <= stmh_pkg::MSG_REJECT;
								qlen_ff <= stmh_pkg::QLEN_ONE;
							end
						end
						else
						begin
							st_ff <= bus.atn ? ST_MO_REQ : ST_CONN;
							req_ff <= bus.atn;
						end
					end
				ST_MI_REQ:
				begin
					io_ff <= 1'b1;
					dout_ff <= q_ff[qidx_ff];
					tpar_ff <= ~^q_ff[qidx_ff];
					if (io_ff && !bus.ack)
						req_ff <= 1'b1;
					if (req_ff && bus.ack)
					begin
						req_ff <= 1'b0;
						st_ff <= ST_MI_ACK;
					end
					if (bus.atn)
						atn_seen_ff <= 1'b1;
				end
				ST_MI_ACK:
					if (!bus.ack)
					begin
						if (bus.atn)
						begin
							// initiator wants the bus: drop the rest and listen
							// a later delivery must not pass as a clean reconnection
							atn_seen_ff <= 1'b1;
							io_ff <= 1'b0;
							req_ff <= 1'b1;
							st_ff <= ST_MO_REQ;
						end
						else if (qidx_ff + stmh_pkg::QIDX_ONE != qlen_ff)
						begin
							qidx_ff <= qidx_ff + stmh_pkg::QIDX_ONE;
							st_ff <= ST_MI_REQ;
						end
						else
						begin
							dlv_ff <= 1'b1;
							ok_ff <= reconn_ff & ~atn_seen_ff;
							reconn_ff <= 1'b0;
							io_ff <= 1'b0;
							st_ff <= rel_ff ? ST_FREE : ST_CONN;
							bsy_ff <= ~rel_ff;
							hold_load_ff <= rel_ff & hold_after_ff;
						end
					end
				default:
					st_ff <= ST_FREE;
			endcase
		end
	end

	always_comb
	begin
		nxt_hold = hold_ff;
		if (hold_load_ff)
			nxt_hold = stmh_max16(DISC_DELAY, disc_limit_i);
		else if (hold_ff != stmh_pkg::HOLD_ZERO)
			nxt_hold = hold_ff - stmh_pkg::HOLD_ONE;
	end

	// the hold flag is registered from the next count so it tracks the counter exactly
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			hold_ff <= stmh_pkg::HOLD_ZERO;
			arb_hold_ff <= 1'b0;
		end
		else
		begin
			hold_ff <= nxt_hold;
			arb_hold_ff <= nxt_hold != stmh_pkg::HOLD_ZERO;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			illegal_ff <= 1'b0;
		else
			illegal_ff <= cmd_valid_i & idv_ff & rsel_ff & cmd_opcode_i != stmh_pkg::OP_INQUIRY &
				cmd_opcode_i != stmh_pkg::OP_REQ_SENSE;
	end

	assign bus.bsy = bsy_ff;
	assign bus.req = req_ff;
	assign bus.io = io_ff;
	assign bus.msgp = bsy_ff;
	assign bus.tdata = dout_ff;
	assign bus.tpar = tpar_ff;
	assign connected_o = bsy_ff;
	assign id_valid_o = idv_ff;
	assign unit_or_routine_number_o = unit_ff;
	assign routine_select_flag_o = rsel_ff;
	assign disconnect_permission_o = dperm_ff;
	assign id_ok_o = ok_ff;
	assign id_bad_o = bad_ff;
	assign unexpected_free_o = unexp_ff;
	assign delivered_o = dlv_ff;
	assign arb_hold_o = arb_hold_ff;
	assign cmd_illegal_o = illegal_ff;
endmodule

// *** design/stmh_initiator.sv ***
// initiator end: answers message phases byte by byte
`timescale 1ns/1ps
module stmh_initiator (
	input wire logic clk_i,
	input wire logic rstn_i,
	stmh_bus_if.initiator bus,
	input wire logic atn_i,
	input wire logic [7:0] out_byte_i,
	output logic out_taken_o,
	output logic in_valid_o,
	output logic [7:0] in_byte_o,
	output logic in_par_err_o,
	output logic restore_ptr_o,
	output logic save_ptr_o
);
	typedef enum {IS_IDLE, IS_ACK} stmh_istate_t;

	stmh_istate_t st_ff;
	logic ack_ff, atn_ff, ipar_ff, taken_ff, inv_ff, perr_ff, rest_ff, save_ff;
	logic [7:0] idata_ff, inb_ff;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			atn_ff <= 1'b0;
		else
			atn_ff <= atn_i;
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			st_ff <= IS_IDLE;
			ack_ff <= 1'b0;
			idata_ff <= 8'h00;
			ipar_ff <= 1'b1;
			taken_ff <= 1'b0;
			inv_ff <= 1'b0;
			inb_ff <= 8'h00;
			perr_ff <= 1'b0;
			rest_ff <= 1'b0;
			save_ff <= 1'b0;
		end
		else
		begin
			taken_ff <= 1'b0;
			inv_ff <= 1'b0;
			perr_ff <= 1'b0;
			rest_ff <= 1'b0;
			save_ff <= 1'b0;
			unique case (st_ff)
				IS_IDLE:
					if (bus.bsy && bus.msgp && bus.req)
					begin
						ack_ff <= 1'b1;
						st_ff <= IS_ACK;
						if (bus.io)
						begin
							inb_ff <= bus.tdata;
							inv_ff <= 1'b1;
							perr_ff <= bus.tpar != ~^bus.tdata;
							// restore before this ACK is released
							rest_ff <= bus.tdata[stmh_pkg::ID_FLAG_BIT];
							// a disconnect alone never saves the pointer
							save_ff <= bus.tdata == stmh_pkg::MSG_SAVE_PTR;
						end
						else
						begin
							idata_ff <= out_byte_i;
							ipar_ff <= ~^out_byte_i;
							taken_ff <= 1'b1;
						end
					end
				IS_ACK:
					if (!bus.req)
					begin
						ack_ff <= 1'b0;
						st_ff <= IS_IDLE;
					end
			endcase
		end
	end

	assign bus.ack = ack_ff;
	assign bus.atn = atn_ff;
	assign bus.idata = idata_ff;
	assign bus.ipar = ipar_ff;
	assign out_taken_o = taken_ff;
	assign in_valid_o = inv_ff;
	assign in_byte_o = inb_ff;
	assign in_par_err_o = perr_ff;
	assign restore_ptr_o = rest_ff;
	assign save_ptr_o = save_ff;
endmodule

// *** tb/stmh_properties.sv ***
// concurrent checks on the message-phase bus joining target and initiator
`timescale 1ns/1ps
module stmh_properties (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic bsy,
	input wire logic req,
	input wire logic io,
	input wire logic msgp,
	input wire logic [7:0] tdata,
	input wire logic tpar,
	input wire logic ack,
	input wire logic atn,
	input wire logic [7:0] idata,
	input wire logic ipar
);
	logic first_ff;
	logic [7:0] last_ff;
	default clocking dck @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	// re-armed while the bus is free so only the opening byte of a connection is judged
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			first_ff <= 1'b1;
		else if (!bsy)
			first_ff <= 1'b1;
		else if (req && ack)
			first_ff <= 1'b0;
	end
	// last inbound byte, so the byte after a residue message can be judged
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			last_ff <= 8'h00;
		else if (!bsy)
			last_ff <= 8'h00;
		else if (req && ack && io)
			last_ff <= tdata;
	end
	chk_tpar_odd: assert property (req |-> ^{tdata, tpar})
		else $error("target parity not odd");
	chk_ipar_odd: assert property (ack && !io |-> ^{idata, ipar})
		else $error("initiator parity not odd");
	chk_req_stands: assert property (req && !ack |=> req || !bsy)
		else $error("request dropped before acknowledge");
	chk_ack_answer: assert property ($rose(req) |=> ack)
		else $error("acknowledge late");
	chk_free_quiet: assert property ($fell(bsy) |-> !req && !ack && !msgp)
		else $error("bus released mid handshake");
	chk_free_no_atn: assert property ($fell(bsy) && $past(io) |-> !$past(atn))
		else $error("released with attention pending");
	chk_id_flag: assert property (first_ff && req && io |-> tdata[7] && tdata[4:3] == 2'h0)
		else $error("reconnect byte is not a valid identify");
	chk_id_noperm: assert property (first_ff && req && io |-> !tdata[6])
		else $error("target sent permission bit");
	chk_residue_code: assert property (last_ff == 8'h23 && req && io |-> tdata inside {8'h01, 8'h02, 8'h03})
		else $error("residue count out of range");
	cov_delivery: cover property ($fell(bsy) && $past(io));
	cov_reconnect: cover property (first_ff && req && io);
	cov_residue: cover property (last_ff == 8'h23 && req && io);
endmodule

// *** tb/testbench.sv ***
// self-checking bench joining the target and initiator ends
`timescale 1ns/1ps
module testbench;
	typedef struct packed
	{
		logic [7:0] idb;
		logic ren;
		logic [1:0] res;
		logic [7:0] op;
		logic ill;
	} stmh_row_t;
	// res: 0 accepted, 1 refused with reject, 2 bus dropped
	stmh_row_t rows [9] = '{'{8'hC5, 1'b0, 2'h0, 8'h28, 1'b0}, '{8'h83, 1'b0, 2'h0, 8'h12, 1'b0},
		'{8'hA2, 1'b1, 2'h0, 8'h03, 1'b0}, '{8'hA7, 1'b1, 2'h0, 8'h12, 1'b0},
		'{8'hA1, 1'b1, 2'h0, 8'h28, 1'b1}, '{8'hA2, 1'b0, 2'h1, 8'h00, 1'b0},
		'{8'h90, 1'b0, 2'h1, 8'h00, 1'b0}, '{8'h88, 1'b0, 2'h1, 8'h00, 1'b0},
		'{8'h02, 1'b0, 2'h2, 8'h00, 1'b0}};
	logic clk_i, rstn_i, select_i, reselect_i, reselect_routine_i, reselect_tagged_i;
	logic complete_i, disconnect_i, save_ptr_i, residue_i, routines_en_i;
	logic init_disc_en_i, can_disc_i, cmd_valid_i, atn_i;
	logic [2:0] reselect_unit_i, unit_or_routine_number_o;
	logic [7:0] reselect_tag_i, residue_code_i, cmd_opcode_i, out_byte_i, in_byte_o, ev;
	logic [15:0] disc_limit_i;
	logic connected_o, id_valid_o, routine_select_flag_o, disconnect_permission_o;
	logic id_ok_o, id_bad_o, unexpected_free_o, delivered_o, arb_hold_o, cmd_illegal_o;
	logic out_taken_o, in_valid_o, in_par_err_o, restore_ptr_o, save_ptr_o;
	logic [7:0] inq [$];
	int evn [8];
	int fails, compares, cyc, n;
	stmh_bus_if bus();
	stmh_target #(.DISC_DELAY(16'h0004)) u_stmh_target (.*);
	stmh_initiator u_stmh_initiator (.*);
	stmh_properties u_stmh_properties (.clk_i(clk_i), .rstn_i(rstn_i), .bsy(bus.bsy),
		.req(bus.req), .io(bus.io), .msgp(bus.msgp), .tdata(bus.tdata), .tpar(bus.tpar),
		.ack(bus.ack), .atn(bus.atn), .idata(bus.idata), .ipar(bus.ipar));
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// event tallies sampled before the edge's own updates land
	always @(posedge clk_i)
	begin
		ev = {in_par_err_o, out_taken_o, restore_ptr_o, save_ptr_o, delivered_o,
			unexpected_free_o, id_bad_o, id_ok_o};
		for (int i = 0; i < 8; i++)
			evn[i] += int'(ev[i] === 1'b1);
		if (in_valid_o === 1'b1)
			inq.push_back(in_byte_o);
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			final_report();
		end
	end
	task final_report();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task check_bit(input string what, input logic e, input logic g);
		compares++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value %s expected %b seen %b", what, e, g);
		end
	endtask
	task check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	task wait_ev(input int k, input int c = 1);
		for (int i = 0; i < 300 && evn[k] < c; i++)
			@(negedge clk_i);
		@(negedge clk_i);
	endtask
	task wait_bsy();
		for (int i = 0; i < 300 && bus.bsy !== 1'b1; i++)
			@(negedge clk_i);
	endtask
	task pop_in(input logic [7:0] e);
		for (int i = 0; i < 300 && inq.size() == 0; i++)
			@(negedge clk_i);
		check_byte("inbound byte", e, inq.size() > 0 ? inq.pop_front() : 8'hXX);
	endtask
	task select(input logic [7:0] idb);
		foreach (evn[i])
			evn[i] = 0;
		inq.delete();
		out_byte_i = idb;
		select_i = 1'b1;
		wait_bsy();
		select_i = 1'b0;
	endtask
	task cmd(input logic [7:0] op, input logic ill);
		logic a;
		cmd_opcode_i = op;
		cmd_valid_i = 1'b1;
		@(posedge clk_i);
		#1 a = cmd_illegal_o;
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		@(posedge clk_i);
		#1 a = a | cmd_illegal_o;
		@(negedge clk_i);
		check_bit("command refused", ill, a);
	endtask
	task close_conn();
		complete_i = 1'b1;
		// wait on the release itself: a reject or reconnect delivery may already be counted
		for (int i = 0; i < 300 && bus.bsy !== 1'b0; i++)
			@(negedge clk_i);
		@(negedge clk_i);
		complete_i = 1'b0;
		pop_in(stmh_pkg::MSG_COMPLETE);
		check_bit("busy after delivery", 1'b0, bus.bsy);
		check_bit("connected after delivery", 1'b0, connected_o);
		check_bit("identity kept", 1'b0, id_valid_o);
		check_bit("parity flag", 1'b0, evn[7] > 0);
	endtask
	initial
	begin
		{select_i, reselect_i, reselect_routine_i, reselect_tagged_i, complete_i} = '0;
		{disconnect_i, save_ptr_i, residue_i, routines_en_i, init_disc_en_i} = '0;
		{can_disc_i, cmd_valid_i, atn_i, rstn_i, reselect_unit_i, reselect_tag_i} = '0;
		{residue_code_i, cmd_opcode_i, out_byte_i} = '0;
		disc_limit_i = 16'h0014;
		repeat (4) @(negedge clk_i);
		rstn_i = 1'b1;
		check_bit("identity in reset", 1'b0, id_valid_o);
		check_bit("idle parity", 1'b1, bus.ipar);
		foreach (rows[i])
		begin
			routines_en_i = rows[i].ren;
			select(rows[i].idb);
			wait_ev(rows[i].res);
			check_bit("id accepted", rows[i].res == 2'h0, evn[0] > 0);
			check_bit("id refused", rows[i].res == 2'h1, evn[1] > 0);
			check_bit("bus dropped", rows[i].res == 2'h2, evn[2] > 0);
			if (rows[i].res == 2'h0)
			begin
				check_byte("unit", 8'(rows[i].idb[2:0]), 8'(unit_or_routine_number_o));
				check_bit("routine flag", rows[i].idb[5], routine_select_flag_o);
				check_bit("permission", rows[i].idb[6], disconnect_permission_o);
				cmd(rows[i].op, rows[i].ill);
			end
			if (rows[i].res == 2'h1)
				pop_in(stmh_pkg::MSG_REJECT);
			if (rows[i].res == 2'h2)
				check_bit("busy after bad opener", 1'b0, bus.bsy);
			else
				close_conn();
		end
		select(8'hC0);
		{reselect_unit_i, reselect_tagged_i, reselect_tag_i} = {3'h6, 1'b1, 8'h5A};
		close_conn();
		evn[5] = 0;
		evn[0] = 0;
		reselect_i = 1'b1;
		wait_bsy();
		reselect_i = 1'b0;
		pop_in(8'h86);
		pop_in(stmh_pkg::MSG_SIMPLE_TAG);
		pop_in(8'h5A);
		wait_ev(0);
		check_bit("pointers restored", 1'b1, evn[5] == 1);
		for (int c = 1; c < 4; c++)
		begin
			residue_code_i = 8'(c);
			residue_i = 1'b1;
			pop_in(stmh_pkg::MSG_WIDE_RESIDUE);
			residue_i = 1'b0;
			pop_in(8'(c));
		end
		n = evn[6];
		out_byte_i = 8'hC6;
		atn_i = 1'b1;
		wait_ev(6, n + 1);
		out_byte_i = 8'h81;
		wait_ev(6, n + 2);
		atn_i = 1'b0;
		check_bit("bus kept on permission change", 1'b0, evn[2] > 0);
		check_bit("permission changed", 1'b1, disconnect_permission_o);
		wait_ev(2);
		check_bit("bus dropped on unit change", 1'b0, bus.bsy);
		select(8'hC1);
		wait_ev(0);
		out_byte_i = stmh_pkg::MSG_DISCONNECT;
		for (int k = 0; k < 3; k++)
		begin
			{init_disc_en_i, can_disc_i} = 2'(k + 1);
			n = evn[6];
			atn_i = 1'b1;
			wait_ev(6, n + 1);
			atn_i = 1'b0;
			pop_in(k < 2 ? stmh_pkg::MSG_REJECT : stmh_pkg::MSG_DISCONNECT);
		end
		wait_ev(3);
		check_bit("busy after requested disconnect", 1'b0, bus.bsy);
		select(8'hC2);
		wait_ev(0);
		{save_ptr_i, disconnect_i} = 2'h3;
		wait_ev(3);
		{save_ptr_i, disconnect_i} = 2'h0;
		pop_in(stmh_pkg::MSG_SAVE_PTR);
		pop_in(stmh_pkg::MSG_DISCONNECT);
		check_bit("one pointer save", 1'b1, evn[4] == 1);
		check_bit("busy after disconnect", 1'b0, bus.bsy);
		{reselect_unit_i, reselect_tagged_i} = 4'h4;
		reselect_i = 1'b1;
		// counting starts about three cycles after release
		for (n = 0; n < 40 && arb_hold_o === 1'b1 && bus.bsy !== 1'b1; n++)
			@(negedge clk_i);
		check_bit("hold time", 1'b1, n >= 17 && n <= 20);
		wait_bsy();
		reselect_i = 1'b0;
		pop_in(8'h82);
		close_conn();
		final_report();
	end
endmodule
